// ### logic/aabie_exec.sv
// Executor for add, AND, bit clear/set and bit test-and-skip
// instructions of a small 8-bit core.
// Assumes decoded operands arrive synchronous to clk, and a file
// register array outside that reads combinationally on regRdAddr
// and writes on the cycle after regWrEn is seen.

// Function
// - Add literal to accumulator, sum into accumulator
// - Literal add updates carry, half-carry, zero
// - Register add sums accumulator with addressed register
// - Destination zero: accumulator; one: file register
// - Literal AND into accumulator, zero flag only
// - Register AND, routed by destination, zero only
// - Bit clear in register, flags unchanged
// - Bit set in register, flags unchanged
// - Skip next when tested bit is low
// - Skip next when tested bit is high
// - Skipped instruction becomes a one-cycle no-op
module aabie_exec #(
    parameter int ADDR_W = aabie_pkg::MAX_ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Decoded instruction
    input wire logic instValid,
    input wire aabie_pkg::aabie_op_t instOp,
    input wire logic [ADDR_W-1:0] instAddr,
    input wire logic [aabie_pkg::BIT_IDX_W-1:0] instBit,
    input wire logic [aabie_pkg::DATA_W-1:0] instLiteral,
    input wire logic instDest,
    // Instruction status
    output logic nopCycle,
    output logic instDiscard,
    output logic execDone,
    // File register array
    output logic [ADDR_W-1:0] regRdAddr,
    input wire logic [aabie_pkg::DATA_W-1:0] regRdData,
    output logic regWrEn,
    output logic [ADDR_W-1:0] regWrAddr,
    output logic [aabie_pkg::DATA_W-1:0] regWrData,
    // Accumulator and flags
    output logic [aabie_pkg::DATA_W-1:0] accum,
    output logic carryFlag,
    output logic halfOverflowBit,
    output logic zeroFlag,
    // Register port
    input wire logic [aabie_pkg::BUS_ADDR_W-1:0] busAddr,
    input wire logic [aabie_pkg::DATA_W-1:0] busWrData,
    input wire logic busWr,
    input wire logic busRd,
    output logic [aabie_pkg::DATA_W-1:0] busRdData
);
    import aabie_pkg::*;

    // ==========================================================
    // Elaboration check
    if (ADDR_W < 1 || ADDR_W > MAX_ADDR_W)
    begin : gAddrCheck
        $error("ADDR_W must lie between 1 and 7");
    end

    // ==========================================================
    // Declarations
    aabie_state_t state_r;
    aabie_state_t state_nxt;
    logic [DATA_W-1:0] accum_r;
    logic carry_r;
    logic halfCarry_r;
    logic zero_r;
    logic regWrEn_r;
    logic [ADDR_W-1:0] regWrAddr_r;
    logic [DATA_W-1:0] regWrData_r;
    logic execDone_r;
    logic [DATA_W-1:0] count_r;
    logic [DATA_W-1:0] busRdData_r;
    logic take;
    logic usesFile;
    logic usesLiteral;
    logic writesFile;
    logic writesAccum;
    logic forwardHit;
    logic [DATA_W-1:0] fileValue;
    logic skipNow;
    logic busWrAccum;
    logic busWrStatus;
    logic busWrCount;
    logic [DATA_W-1:0] statusView;

    aabie_alu_if aluIf ();

    // ==========================================================
    // Arithmetic unit
    aabie_alu uAlu (
        .aluIf(aluIf.alu)
    );

    // ==========================================================
    // Instruction acceptance
    // A word offered during the no-op cycle is consumed but dropped
    assign take = instValid && (state_r == ST_EXEC);
    assign instDiscard = instValid && (state_r == ST_NOP);

    // Operand class of the offered instruction
    always_comb
    begin
        usesFile = 1'b0;
        usesLiteral = 1'b0;
        case (instOp)
            OP_ADD_IMM, OP_AND_IMM:
                usesLiteral = 1'b1;
            OP_ADD_REG, OP_AND_REG, OP_CLR_BIT, OP_SET_BIT,
            OP_TEST_LOW, OP_TEST_HIGH:
                usesFile = 1'b1;
            default:
                usesFile = 1'b0;
        endcase
    end

    // ==========================================================
    // File register read with forwarding
    // The write of the previous instruction lands one cycle late,
    // so a back-to-back read of the same address takes it here.
    assign regRdAddr = instAddr;
    assign forwardHit = regWrEn_r && (regWrAddr_r == instAddr);
    assign fileValue = forwardHit ? regWrData_r : regRdData;

    // ==========================================================
    // Operand routing into the arithmetic unit
    assign aluIf.op = take ? instOp : OP_NONE;
    assign aluIf.accIn = accum_r;
    assign aluIf.operand = usesLiteral ? instLiteral : fileValue;
    assign aluIf.bitIdx = instBit;

    // ==========================================================
    // Destination decode
    always_comb
    begin
        writesFile = 1'b0;
        writesAccum = 1'b0;
        case (instOp)
            OP_ADD_IMM, OP_AND_IMM:
                writesAccum = 1'b1;
            OP_ADD_REG, OP_AND_REG:
            begin
                writesFile = (instDest == DEST_FILE);
                writesAccum = (instDest == DEST_ACCUM);
            end
            OP_CLR_BIT, OP_SET_BIT:
                writesFile = 1'b1;
            default:
                writesFile = 1'b0;
        endcase
    end

    // ==========================================================
    // Skip decision
    always_comb
    begin
        skipNow = 1'b0;
        case (instOp)
            OP_TEST_LOW:
                skipNow = take && !aluIf.bitValue;
            OP_TEST_HIGH:
                skipNow = take && aluIf.bitValue;
            default:
                skipNow = 1'b0;
        endcase
    end

    // Next state of the sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_EXEC:
                if (skipNow)
                begin
                    state_nxt = ST_NOP;
                end
            ST_NOP:
                state_nxt = ST_EXEC;
            default:
                state_nxt = ST_EXEC;
        endcase
    end

    // Sequencer register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= ST_EXEC;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Register port decode
    assign busWrAccum = busWr && (busAddr == ACCUM_OFF);
    assign busWrStatus = busWr && (busAddr == STATUS_OFF);
    assign busWrCount = busWr && (busAddr == COUNT_OFF);

    // ==========================================================
    // Accumulator; a port write wins over an instruction result
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            accum_r <= ACCUM_RST;
        end
        else if (busWrAccum)
        begin
            accum_r <= busWrData;
        end
        else if (take && writesAccum)
        begin
            accum_r <= aluIf.result;
        end
    end

    // Carry and half-carry follow additions only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            carry_r <= FLAG_RST;
            halfCarry_r <= FLAG_RST;
        end
        else if (busWrStatus)
        begin
            carry_r <= busWrData[CARRY_POS];
            halfCarry_r <= busWrData[HALF_POS];
        end
        else if (take && aluIf.updArith)
        begin
            carry_r <= aluIf.carry;
            halfCarry_r <= aluIf.halfCarry;
        end
    end

    // Zero flag follows additions and ANDs; bit ops leave it alone
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            zero_r <= FLAG_RST;
        end
        else if (busWrStatus)
        begin
            zero_r <= busWrData[ZERO_POS];
        end
        else if (take && aluIf.updZero)
        begin
            zero_r <= aluIf.zero;
        end
    end

    // ==========================================================
    // File register write-back, issued one cycle after take
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            regWrEn_r <= 1'b0;
            regWrAddr_r <= '0;
            regWrData_r <= '0;
        end
        else
        begin
            regWrEn_r <= take && writesFile;
            if (take && writesFile)
            begin
                regWrAddr_r <= instAddr;
                regWrData_r <= aluIf.result;
            end
        end
    end

    // ==========================================================
    // Completion pulse and executed-instruction counter
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            execDone_r <= 1'b0;
        end
        else
        begin
            execDone_r <= take && (usesFile || usesLiteral);
        end
    end

    // Counter wraps; a port write reloads it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_r <= COUNT_RST;
        end
        else if (busWrCount)
        begin
            count_r <= busWrData;
        end
        else if (take && (usesFile || usesLiteral))
        begin
            count_r <= count_r + 8'h01;
        end
    end

    // ==========================================================
    // Register port read data, one cycle after the strobe
    always_comb
    begin
        statusView = '0;
        statusView[CARRY_POS] = carry_r;
        statusView[HALF_POS] = halfCarry_r;
        statusView[ZERO_POS] = zero_r;
        statusView[SKIP_POS] = (state_r == ST_NOP);
    end

    // Unmapped offsets read as zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busRdData_r <= '0;
        end
        else if (busRd)
        begin
            case (busAddr)
                ACCUM_OFF: busRdData_r <= accum_r;
                STATUS_OFF: busRdData_r <= statusView;
                COUNT_OFF: busRdData_r <= count_r;
                default: busRdData_r <= '0;
            endcase
        end
        else
        begin
            busRdData_r <= '0;
        end
    end

    // ==========================================================
    // Outputs
    assign nopCycle = (state_r == ST_NOP);
    assign execDone = execDone_r;
    assign regWrEn = regWrEn_r;
    assign regWrAddr = regWrAddr_r;
    assign regWrData = regWrData_r;
    assign accum = accum_r;
    assign carryFlag = carry_r;
    assign halfOverflowBit = halfCarry_r;
    assign zeroFlag = zero_r;
    assign busRdData = busRdData_r;
endmodule // aabie_exec

// ### logic/aabie_pkg.sv
// Shared constants and types of the add/AND/bit instruction executor.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package aabie_pkg;
    // ==========================================================
    // Data path widths
    localparam int DATA_W = 8;
    localparam int BIT_IDX_W = 3;
    localparam int MAX_ADDR_W = 7;
    localparam int BUS_ADDR_W = 4;

    // ==========================================================
    // Destination selector values
    localparam logic DEST_ACCUM = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    // ==========================================================
    // Register port offsets
    localparam logic [BUS_ADDR_W-1:0] ACCUM_OFF = 4'h0;
    localparam logic [BUS_ADDR_W-1:0] STATUS_OFF = 4'h1;
    localparam logic [BUS_ADDR_W-1:0] COUNT_OFF = 4'h2;

    // ==========================================================
    // Status register field positions
    localparam int CARRY_POS = 0;
    localparam int HALF_POS = 1;
    localparam int ZERO_POS = 2;
    localparam int SKIP_POS = 3;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;
    localparam logic FLAG_RST = 1'h0;

    // ==========================================================
    // Operation selector
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD_IMM = 4'h1,
        OP_ADD_REG = 4'h2,
        OP_AND_IMM = 4'h3,
        OP_AND_REG = 4'h4,
        OP_CLR_BIT = 4'h5,
        OP_SET_BIT = 4'h6,
        OP_TEST_LOW = 4'h7,
        OP_TEST_HIGH = 4'h8
    } aabie_op_t;

    // ==========================================================
    // Sequencer states, Gray coded
    typedef enum logic [0:0] {
        ST_EXEC = 1'h0,
        ST_NOP = 1'h1
    } aabie_state_t;
endpackage

// ### logic/aabie_alu_if.sv
// Carrier between the executor and its arithmetic unit.
// Assumes both ends run combinationally inside one clock domain.
interface aabie_alu_if;
    import aabie_pkg::*;
    // ==========================================================
    // Operands
    aabie_op_t op;
    logic [DATA_W-1:0] accIn;
    logic [DATA_W-1:0] operand;
    logic [BIT_IDX_W-1:0] bitIdx;
    // ==========================================================
    // Results
    logic [DATA_W-1:0] result;
    logic carry;
    logic halfCarry;
    logic zero;
    logic updArith;
    logic updZero;
    logic bitValue;

    modport client (
        output op, accIn, operand, bitIdx,
        input result, carry, halfCarry, zero, updArith, updZero, bitValue
    );
    modport alu (
        input op, accIn, operand, bitIdx,
        output result, carry, halfCarry, zero, updArith, updZero, bitValue
    );
endinterface

// ### logic/aabie_alu.sv
// Combinational arithmetic unit: add, AND, bit clear/set, bit pick.
// Assumes operands are stable for the whole cycle.
module aabie_alu (
    // Operand and result bundle
    aabie_alu_if.alu aluIf
);
    import aabie_pkg::*;

    logic [DATA_W:0] sumFull;
    logic [4:0] sumLow;
    logic [DATA_W-1:0] bitMask;

    // ==========================================================
    // Adders and bit mask
    assign sumFull = {1'b0, aluIf.accIn} + {1'b0, aluIf.operand};
    assign sumLow = {1'b0, aluIf.accIn[3:0]} + {1'b0, aluIf.operand[3:0]};
    assign bitMask = DATA_W'(1) << aluIf.bitIdx;
    assign aluIf.bitValue = aluIf.operand[aluIf.bitIdx];
    assign aluIf.zero = (aluIf.result == '0);
    assign aluIf.carry = sumFull[DATA_W];
    assign aluIf.halfCarry = sumLow[4];

    // Result select and flag update enables
    always_comb
    begin
        aluIf.result = aluIf.operand;
        aluIf.updArith = 1'b0;
        aluIf.updZero = 1'b0;
        case (aluIf.op)
            OP_ADD_IMM, OP_ADD_REG:
            begin
                aluIf.result = sumFull[DATA_W-1:0];
                aluIf.updArith = 1'b1;
                aluIf.updZero = 1'b1;
            end
            OP_AND_IMM, OP_AND_REG:
            begin
                aluIf.result = aluIf.accIn & aluIf.operand;
                aluIf.updZero = 1'b1;
            end
            OP_CLR_BIT:
                aluIf.result = aluIf.operand & ~bitMask;
            OP_SET_BIT:
                aluIf.result = aluIf.operand | bitMask;
            default:
                aluIf.result = aluIf.operand;
        endcase
    end
endmodule // aabie_alu

// ### dv/aabie_exec_assertions.sv
// Checker for the add/AND/bit executor, bound to its ports.
// Assumes one clock and the synchronous active-low reset.
module aabie_exec_checker #(
    parameter int ADDR_W = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction
    input wire logic instValid,
    input wire aabie_pkg::aabie_op_t instOp,
    input wire logic [ADDR_W-1:0] instAddr,
    input wire logic [2:0] instBit,
    input wire logic [7:0] instLiteral,
    input wire logic instDest,
    input wire logic nopCycle,
    input wire logic instDiscard,
    // File registers
    input wire logic [7:0] regRdData,
    input wire logic regWrEn,
    input wire logic [ADDR_W-1:0] regWrAddr,
    input wire logic [7:0] regWrData,
    // Accumulator, flags, port
    input wire logic [7:0] accum,
    input wire logic carryFlag,
    input wire logic halfOverflowBit,
    input wire logic zeroFlag,
    input wire logic busWr
);
    timeunit 1ns;
    timeprecision 1ns;
    import aabie_pkg::*;
    logic take, selBit;
    logic [1:0] ch;
    logic [2:0] flags;
    // =========================================================
    // Helpers: taken op without forwarding or port write
    assign take = instValid && !nopCycle && !busWr &&
        !(regWrEn && regWrAddr == instAddr);
    assign selBit = regRdData[instBit];
    assign ch = {carryFlag, halfOverflowBit};
    assign flags = {carryFlag, halfOverflowBit, zeroFlag};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_add_imm_sum: assert property (
        take && instOp == OP_ADD_IMM
        |=> accum == 8'($past(accum) + $past(instLiteral)))
        else $error("literal add sum wrong");
    a_add_flags: assert property (
        take && instOp == OP_ADD_IMM
        |=> carryFlag == ($past(accum) + $past(instLiteral) > 255) &&
        halfOverflowBit == ($past(accum) % 16 + $past(instLiteral) % 16 > 15)
        && zeroFlag == (accum == 8'h00))
        else $error("literal add flags wrong");
    a_add_reg_file: assert property (
        take && instOp == OP_ADD_REG && instDest == DEST_FILE
        |=> regWrEn && regWrAddr == $past(instAddr) && $stable(accum) &&
        regWrData == 8'($past(accum) + $past(regRdData)))
        else $error("register add to file wrong");
    a_and_reg_acc: assert property (
        take && instOp == OP_AND_REG && instDest == DEST_ACCUM
        |=> !regWrEn && accum == ($past(accum) & $past(regRdData)) &&
        zeroFlag == (accum == 8'h00) && $stable(ch))
        else $error("register AND to accumulator wrong");
    a_and_imm_zero: assert property (
        take && instOp == OP_AND_IMM
        |=> accum == ($past(accum) & $past(instLiteral)) &&
        zeroFlag == (accum == 8'h00) && $stable(ch))
        else $error("literal AND wrong");
    a_clear_bit: assert property (
        take && instOp == OP_CLR_BIT |=> regWrEn && $stable(flags) &&
        regWrData == ($past(regRdData) & ~(8'h01 << $past(instBit))))
        else $error("bit clear wrong");
    a_set_bit: assert property (
        take && instOp == OP_SET_BIT |=> regWrEn && $stable(flags) &&
        regWrData == ($past(regRdData) | (8'h01 << $past(instBit))))
        else $error("bit set wrong");
    a_skip_low: assert property (
        take && instOp == OP_TEST_LOW
        |=> nopCycle == !$past(selBit) && $stable(flags) && !regWrEn)
        else $error("skip on low bit wrong");
    a_skip_high: assert property (
        take && instOp == OP_TEST_HIGH
        |=> nopCycle == $past(selBit) && $stable(flags) && !regWrEn)
        else $error("skip on high bit wrong");
    a_nop_drop: assert property (
        nopCycle && !busWr |-> instDiscard == instValid
        ##1 !nopCycle && !regWrEn && $stable(accum))
        else $error("no-op cycle not dropping word");
endmodule // aabie_exec_checker

bind aabie_exec aabie_exec_checker #(.ADDR_W(ADDR_W)) aabie_exec_checker_i (
    .clk(clk), .rst_n(rst_n), .instValid(instValid), .instOp(instOp),
    .instAddr(instAddr), .instBit(instBit), .instLiteral(instLiteral),
    .instDest(instDest), .nopCycle(nopCycle), .instDiscard(instDiscard),
    .regRdData(regRdData), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .accum(accum), .carryFlag(carryFlag),
    .halfOverflowBit(halfOverflowBit), .zeroFlag(zeroFlag), .busWr(busWr)
);

// ### dv/aabie_regfile_model.sv
// File register array model on the executor's far side.
// Assumes combinational reads and writes landing at the clock edge.
module aabie_regfile_model (
    // Clock
    input wire logic clk,
    // Read side
    input wire logic [6:0] regRdAddr,
    output logic [7:0] regRdData,
    // Write side
    input wire logic regWrEn,
    input wire logic [6:0] regWrAddr,
    input wire logic [7:0] regWrData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [128];
    // Seeded contents, same pattern as the bench mirror
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 5);
    end
    // Combinational read
    assign regRdData = mem[regRdAddr];
    // Write at the edge after the strobe
    always @(posedge clk)
        if (regWrEn)
            mem[regWrAddr] <= regWrData;
endmodule // aabie_regfile_model

// ### dv/tb_aabie_exec.sv
// Self-checking bench for the add/AND/bit executor.
// Assumes the file register model and the bound checker.
module tb_aabie_exec;
    timeunit 1ns;
    timeprecision 1ns;
    import aabie_pkg::*;
    typedef struct packed {
        logic [7:0] acc;
        logic c, h, z, we;
        logic [6:0] wa;
        logic [7:0] wd;
        logic nop;
    } aabie_exp_t;
    // =========================================================
    // Signals and mirror state
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instValid = 1'b0;
    logic instDest = 1'b0;
    aabie_op_t instOp = OP_NONE;
    logic [6:0] instAddr = 7'h00;
    logic [2:0] instBit = 3'h0;
    logic [7:0] instLiteral = 8'h00;
    logic [3:0] busAddr = 4'h0;
    logic [7:0] busWrData = 8'h00;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic rdPend = 1'b0;
    logic nopCycle, instDiscard, execDone, regWrEn;
    logic carryFlag, halfOverflowBit, zeroFlag;
    logic [6:0] regRdAddr, regWrAddr;
    logic [7:0] regRdData, regWrData, accum, busRdData;
    logic [7:0] acc = 8'h00;
    logic [7:0] count = 8'h00;
    logic c = 1'b0, h = 1'b0, z = 1'b0;
    logic [7:0] mem [128];
    aabie_exp_t expQ[$];
    logic [7:0] rdQ[$];
    int miscompares = 0;
    int cmp_count = 0;
    integer seed = 32'h30E8;
    // Clock
    always #5 clk = ~clk;
    aabie_exec #(.ADDR_W(7)) aabie_exec_i (
        .clk(clk), .rst_n(rst_n), .instValid(instValid), .instOp(instOp),
        .instAddr(instAddr), .instBit(instBit), .instLiteral(instLiteral),
        .instDest(instDest), .nopCycle(nopCycle), .instDiscard(instDiscard),
        .execDone(execDone), .regRdAddr(regRdAddr), .regRdData(regRdData),
        .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
        .accum(accum), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
        .halfOverflowBit(halfOverflowBit), .busAddr(busAddr),
        .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
        .busRdData(busRdData));
    aabie_regfile_model aabie_regfile_model_i (
        .clk(clk), .regRdAddr(regRdAddr), .regRdData(regRdData),
        .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData));
    // =========================================================
    // Reporting and compares
    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", cmp_count,
            miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic miss(input string m);
        miscompares++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic chk_exec(input aabie_exp_t e);
        aabie_exp_t g;
        g = {accum, carryFlag, halfOverflowBit, zeroFlag, regWrEn,
            regWrEn ? regWrAddr : 7'h00, regWrEn ? regWrData : 8'h00,
            nopCycle};
        cmp_count++;
        if (g !== e)
            miss($sformatf("result %h expected %h", g, e));
    endtask
    task automatic chk_bus(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
            miss($sformatf("read %h expected %h", g, e));
    endtask
    // Scoreboard: results taken in order as they appear
    always @(posedge clk)
    begin
        if (execDone === 1'b1)
        begin
            if (expQ.size() == 0)
                miss("unexpected result");
            else
                chk_exec(expQ.pop_front());
        end
        if (rdPend)
            chk_bus(busRdData, rdQ.pop_front());
        else if (rst_n)
            chk_bus(busRdData, 8'h00);
        rdPend = busRd;
    end
    // =========================================================
    // Drivers with mirror of the expected state
    task automatic run(input aabie_op_t op, input logic [6:0] a,
        input logic [2:0] b, input logic [7:0] k, input logic d);
        aabie_exp_t e;
        logic [8:0] s;
        logic [7:0] v;
        logic [7:0] r;
        e = '0;
        v = mem[a];
        r = (op inside {OP_ADD_IMM, OP_AND_IMM}) ? k : v;
        case (op)
            OP_ADD_IMM, OP_ADD_REG:
            begin
                s = {1'b0, acc} + {1'b0, r};
                h = acc[3:0] + r[3:0] > 15;
                c = s[8];
                r = s[7:0];
                z = r == 8'h00;
            end
            OP_AND_IMM, OP_AND_REG:
            begin
                r = acc & r;
                z = r == 8'h00;
            end
            OP_CLR_BIT: r = v & ~(8'h01 << b);
            OP_SET_BIT: r = v | (8'h01 << b);
            default: e.nop = v[b] ^ (op == OP_TEST_LOW);
        endcase
        e.we = (op inside {OP_CLR_BIT, OP_SET_BIT}) ||
            (d && (op inside {OP_ADD_REG, OP_AND_REG}));
        if (e.we)
            mem[a] = r;
        else if (op inside {OP_ADD_IMM, OP_ADD_REG, OP_AND_IMM, OP_AND_REG})
            acc = r;
        e.wa = e.we ? a : 7'h00;
        e.wd = e.we ? r : 8'h00;
        {e.acc, e.c, e.h, e.z} = {acc, c, h, z};
        expQ.push_back(e);
        count++;
        instValid <= 1'b1;
        instOp <= op;
        instAddr <= a;
        instBit <= b;
        instLiteral <= k;
        instDest <= d;
        @(posedge clk);
        if (e.nop)
        begin
            instOp <= OP_SET_BIT; // Would write if not dropped
            @(posedge clk);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [7:0] d);
        if (!w)
            rdQ.push_back(d);
        if (w && a == ACCUM_OFF)
            acc = d;
        if (w && a == STATUS_OFF)
            {z, h, c} = d[2:0];
        if (w && a == COUNT_OFF)
            count = d;
        busWr <= w;
        busRd <= !w;
        busAddr <= a;
        busWrData <= d;
        @(posedge clk);
    endtask
    task automatic idle();
        instValid <= 1'b0;
        instOp <= OP_NONE;
        busWr <= 1'b0;
        busRd <= 1'b0;
        @(posedge clk);
    endtask
    // Watchdog against a hang
    initial
    begin
        #20000;
        miss("timeout");
        test_done();
    end
    // Main sequence
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 5);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(0, ACCUM_OFF, ACCUM_RST);
        bus(0, STATUS_OFF, 8'h00);
        bus(0, COUNT_OFF, COUNT_RST);
        bus(1, 4'hF, 8'hFF);
        bus(0, 4'hF, 8'h00);
        bus(1, ACCUM_OFF, 8'h88);
        idle();
        $display("Test reset and port done");
        run(OP_ADD_IMM, 7'h00, 3'h0, 8'h78, 1'b0);
        run(OP_AND_IMM, 7'h00, 3'h0, 8'hFF, 1'b0);
        run(OP_ADD_IMM, 7'h00, 3'h0, 8'h01, 1'b0);
        run(OP_ADD_REG, 7'h7F, 3'h7, 8'h00, DEST_FILE);
        $display("Test carry boundary done");
        idle();
        bus(1, STATUS_OFF, 8'hFD);
        bus(0, STATUS_OFF, 8'h05);
        bus(1, COUNT_OFF, 8'hFE);
        bus(0, COUNT_OFF, 8'hFE);
        idle();
        for (int i = 0; i < 240; i++)
            run(aabie_op_t'(4'(i % 8 + 1)), 7'($random(seed)),
                3'($random(seed)), 8'($random(seed)),
                1'($random(seed)));
        idle();
        bus(0, ACCUM_OFF, acc);
        bus(0, STATUS_OFF, {5'h00, z, h, c});
        bus(0, COUNT_OFF, count);
        idle();
        @(posedge clk);
        if (expQ.size() != 0)
            miss("results missing");
        $display("Test random operations done");
        test_done();
    end
endmodule // tb_aabie_exec
